/* hdl/usc_pkg.sv */
// ====================================================================
// shadow control slice: shared constants
package usc_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_LINE_CTRL = 32'h5000100c;
  localparam logic [31:0] ADDR_MODEM_CTRL = 32'h50001010;
  localparam logic [31:0] ADDR_FIFO_CTRL = 32'h50001008;
  localparam logic [31:0] ADDR_BRK_SHADOW = 32'h50001090;
  localparam logic [31:0] ADDR_DMAM_SHADOW = 32'h50001094;
  localparam logic [31:0] ADDR_FEN_SHADOW = 32'h50001098;
  localparam logic [31:0] ADDR_RTRIG_SHADOW = 32'h5000109c;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h500010e0;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h500010e4;
  // field positions
  localparam int LCR_BRK_BIT = 6;
  localparam int MCR_LOOP_BIT = 4;
  localparam int MCR_IR_BIT = 6;
  localparam int FCR_FEN_BIT = 0;
  localparam int FCR_RXRST_BIT = 1;
  localparam int FCR_TXRST_BIT = 2;
  localparam int FCR_DMAM_BIT = 3;
  localparam int FCR_RTRIG_LSB = 6;
  // interrupt status bits
  localparam int EV_RX_AVAIL = 0;
  localparam int EV_FIFO_RST = 1;
  localparam int EV_BRK_START = 2;
  localparam int EV_W = 3;
  // reset values
  localparam logic [7:0] LCR_RST = 8'h00;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [1:0] RTRIG_RST = 2'h0;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;
  // fifo geometry
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W = 5;
  localparam logic [LVL_W-1:0] LVL_ONE = 5'h01;
  localparam logic [LVL_W-1:0] LVL_QUARTER = 5'h04;
  localparam logic [LVL_W-1:0] LVL_HALF = 5'h08;
  localparam logic [LVL_W-1:0] LVL_TWO_LESS = 5'h0e;
  localparam logic [LVL_W-1:0] LVL_FULL = 5'h10;
  // infrared break pulse timing
  localparam int SIR_HALF_NS = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SIR_HALF_CYC = SIR_HALF_NS / CLK_PERIOD_NS;
  localparam int SIR_CNT_W = 8;
  // trigger codes
  typedef enum logic [1:0] {
    USC_TRIG_ONE = 2'b00,
    USC_TRIG_QUARTER = 2'b01,
    USC_TRIG_HALF = 2'b10,
    USC_TRIG_TWO_LESS = 2'b11
  } usc_trig_t;
endpackage

/* hdl/usc_shadow.sv */
// Notes on behaviour
// - break shadow and line control bit six are one shared state
// - break set drives the serial output to the spacing level, zero
// - outside loopback the output stays low until break is cleared
// - infrared mode with break set pulses the infrared output
// - in loopback the break goes to the receiver input, not the pin
// - dma mode shadow aliases fifo control bit three, mode 0 or 1
// - fifo enable shadow aliases bit zero, both fifos together
// - fifo enable falling resets control of both fifos
// - receive trigger shadow aliases bits seven:six, sets ready level
// - dma mode one asserts receive request at the trigger level
// - loopback means modem control bit four is one
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module usc_shadow (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_tx_serial,
  input wire logic i_tx_sir_n,
  input wire logic [4:0] i_rx_level,
  input wire logic [4:0] i_tx_level,
  output logic o_sout,
  output logic o_sir_out_n,
  output logic o_loop_rx,
  output logic o_fifo_en,
  output logic o_tx_ctl_rst,
  output logic o_rx_ctl_rst,
  output logic o_rx_avail,
  output logic o_dma_tx_req_n,
  output logic o_dma_rx_req_n,
  output logic o_irq
);
  // ==================================================================
  // state
  logic [7:0] lcr_r, lcr_nxt;
  logic [7:0] mcr_r, mcr_nxt;
  logic brk_r, brk_nxt;
  logic dmam_r, dmam_nxt;
  logic fen_r, fen_nxt;
  logic [1:0] rtrig_r, rtrig_nxt;
  logic [2:0] mask_r, mask_nxt;
  logic [2:0] stat_r, stat_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic txrst_r, txrst_nxt;
  logic rxrst_r, rxrst_nxt;
  logic sout_r, sout_nxt;
  logic loop_rx_r, loop_rx_nxt;
  logic sir_r, sir_nxt;
  logic [7:0] sir_cnt_r, sir_cnt_nxt;
  logic rda_r, rda_nxt;
  logic drx_r, drx_nxt;
  logic dtx_r, dtx_nxt;
  logic wr_en, rd_setup, mapped, loop_on, ir_on, ir_brk;
  logic [4:0] thr;
  logic [2:0] ev;

  // ==================================================================
  // bus decode
  always_comb begin
    unique case (i_paddr)
      usc_pkg::ADDR_LINE_CTRL, usc_pkg::ADDR_MODEM_CTRL,
      usc_pkg::ADDR_FIFO_CTRL, usc_pkg::ADDR_BRK_SHADOW,
      usc_pkg::ADDR_DMAM_SHADOW, usc_pkg::ADDR_FEN_SHADOW,
      usc_pkg::ADDR_RTRIG_SHADOW, usc_pkg::ADDR_IRQ_STATUS,
      usc_pkg::ADDR_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign wr_en = i_psel & i_penable & i_pwrite & mapped;
  assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
  // read data is latched in setup, so every access has no wait state
  assign o_pready = i_psel & i_penable;
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign o_prdata = prdata_r;

  assign loop_on = mcr_r[usc_pkg::MCR_LOOP_BIT];
  assign ir_on = mcr_r[usc_pkg::MCR_IR_BIT];
  assign ir_brk = ir_on & brk_r & ~loop_on;

  // ==================================================================
  // receive trigger level
  always_comb begin
    if (!fen_r) begin
      thr = usc_pkg::LVL_ONE;
    end else begin
      unique case (usc_pkg::usc_trig_t'(rtrig_r))
        usc_pkg::USC_TRIG_ONE: thr = usc_pkg::LVL_ONE;
        usc_pkg::USC_TRIG_QUARTER: thr = usc_pkg::LVL_QUARTER;
        usc_pkg::USC_TRIG_HALF: thr = usc_pkg::LVL_HALF;
        usc_pkg::USC_TRIG_TWO_LESS: thr = usc_pkg::LVL_TWO_LESS;
      endcase
    end
  end

  // ==================================================================
  // register writes and control next state
  always_comb begin
    lcr_nxt = lcr_r;
    mcr_nxt = mcr_r;
    brk_nxt = brk_r;
    dmam_nxt = dmam_r;
    fen_nxt = fen_r;
    rtrig_nxt = rtrig_r;
    mask_nxt = mask_r;
    txrst_nxt = 1'b0;
    rxrst_nxt = 1'b0;
    if (wr_en) begin
      unique case (i_paddr)
        usc_pkg::ADDR_LINE_CTRL: begin
          lcr_nxt = i_pwdata[7:0];
          brk_nxt = i_pwdata[usc_pkg::LCR_BRK_BIT];
        end
        usc_pkg::ADDR_MODEM_CTRL: mcr_nxt = i_pwdata[7:0];
        usc_pkg::ADDR_FIFO_CTRL: begin
          fen_nxt = i_pwdata[usc_pkg::FCR_FEN_BIT];
          dmam_nxt = i_pwdata[usc_pkg::FCR_DMAM_BIT];
          rtrig_nxt = i_pwdata[usc_pkg::FCR_RTRIG_LSB +: 2];
          rxrst_nxt = i_pwdata[usc_pkg::FCR_RXRST_BIT];
          txrst_nxt = i_pwdata[usc_pkg::FCR_TXRST_BIT];
        end
        usc_pkg::ADDR_BRK_SHADOW: brk_nxt = i_pwdata[0];
        usc_pkg::ADDR_DMAM_SHADOW: dmam_nxt = i_pwdata[0];
        usc_pkg::ADDR_FEN_SHADOW: fen_nxt = i_pwdata[0];
        usc_pkg::ADDR_RTRIG_SHADOW: rtrig_nxt = i_pwdata[1:0];
        usc_pkg::ADDR_IRQ_MASK: mask_nxt = i_pwdata[2:0];
        default: ;
      endcase
    end
    // disabling the fifos clears both control portions
    if (fen_r && !fen_nxt) begin
      txrst_nxt = 1'b1;
      rxrst_nxt = 1'b1;
    end
  end

  // ==================================================================
  // read data, latched in the setup cycle
  always_comb begin
    prdata_nxt = prdata_r;
    if (rd_setup) begin
      prdata_nxt = 32'h00000000;
      unique case (i_paddr)
        usc_pkg::ADDR_LINE_CTRL: begin
          prdata_nxt[7:0] = lcr_r;
          prdata_nxt[usc_pkg::LCR_BRK_BIT] = brk_r;
        end
        usc_pkg::ADDR_MODEM_CTRL: prdata_nxt[7:0] = mcr_r;
        usc_pkg::ADDR_FIFO_CTRL: begin
          prdata_nxt[usc_pkg::FCR_FEN_BIT] = fen_r;
          prdata_nxt[usc_pkg::FCR_DMAM_BIT] = dmam_r;
          prdata_nxt[usc_pkg::FCR_RTRIG_LSB +: 2] = rtrig_r;
        end
        usc_pkg::ADDR_BRK_SHADOW: prdata_nxt[0] = brk_r;
        usc_pkg::ADDR_DMAM_SHADOW: prdata_nxt[0] = dmam_r;
        usc_pkg::ADDR_FEN_SHADOW: prdata_nxt[0] = fen_r;
        usc_pkg::ADDR_RTRIG_SHADOW: prdata_nxt[1:0] = rtrig_r;
        usc_pkg::ADDR_IRQ_STATUS: prdata_nxt[2:0] = stat_r;
        usc_pkg::ADDR_IRQ_MASK: prdata_nxt[2:0] = mask_r;
        default: ;
      endcase
    end
  end

  // ==================================================================
  // serial line, loopback and infrared break
  // infrared break period is a fixed constant; software cannot tune it
  always_comb begin
    sir_cnt_nxt = 8'h00;
    sir_nxt = 1'b1;
    if (ir_brk) begin
      sir_nxt = sir_r;
      sir_cnt_nxt = sir_cnt_r + 8'h01;
      if (sir_cnt_r == 8'(usc_pkg::SIR_HALF_CYC - 1)) begin
        sir_cnt_nxt = 8'h00;
        sir_nxt = ~sir_r;
      end
    end else if (ir_on && !loop_on) begin
      sir_nxt = i_tx_sir_n;
    end
    if (loop_on) begin
      sout_nxt = 1'b1;
      loop_rx_nxt = i_tx_serial & ~brk_r;
    end else begin
      sout_nxt = i_tx_serial & ~brk_r;
      loop_rx_nxt = 1'b1;
    end
  end

  // ==================================================================
  // data ready, dma requests and interrupts
  always_comb begin
    rda_nxt = (i_rx_level >= thr);
    if (dmam_r) begin
      // mode 1 keeps asking until the fifo drains
      drx_nxt = (i_rx_level >= thr) | (drx_r & (i_rx_level != 5'h00));
      // transmit side asks for as long as there is room left
      dtx_nxt = (i_tx_level < usc_pkg::LVL_FULL);
    end else begin
      drx_nxt = (i_rx_level != 5'h00);
      dtx_nxt = (i_tx_level == 5'h00);
    end
    if (txrst_r || rxrst_r) begin
      drx_nxt = 1'b0;
    end
    ev = 3'h0;
    ev[usc_pkg::EV_RX_AVAIL] = rda_nxt & ~rda_r;
    ev[usc_pkg::EV_FIFO_RST] = txrst_nxt | rxrst_nxt;
    ev[usc_pkg::EV_BRK_START] = brk_nxt & ~brk_r;
    stat_nxt = stat_r;
    if (wr_en && i_paddr == usc_pkg::ADDR_IRQ_STATUS) begin
      stat_nxt = stat_r & ~i_pwdata[2:0];
    end
    // a new event wins over a clear in the same cycle
    stat_nxt = stat_nxt | ev;
  end

  assign o_irq = |(stat_r & mask_r);
  assign o_sout = sout_r;
  assign o_sir_out_n = sir_r;
  assign o_loop_rx = loop_rx_r;
  assign o_fifo_en = fen_r;
  assign o_tx_ctl_rst = txrst_r;
  assign o_rx_ctl_rst = rxrst_r;
  assign o_rx_avail = rda_r;
  assign o_dma_rx_req_n = ~drx_r;
  assign o_dma_tx_req_n = ~dtx_r;

  // ==================================================================
  // registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lcr_r <= usc_pkg::LCR_RST;
      mcr_r <= usc_pkg::MCR_RST;
      brk_r <= 1'b0;
      dmam_r <= 1'b0;
      fen_r <= 1'b0;
      rtrig_r <= usc_pkg::RTRIG_RST;
      mask_r <= usc_pkg::MASK_RST;
      stat_r <= 3'h0;
      prdata_r <= 32'h00000000;
      txrst_r <= 1'b0;
      rxrst_r <= 1'b0;
      sout_r <= 1'b1;
      loop_rx_r <= 1'b1;
      sir_r <= 1'b1;
      sir_cnt_r <= 8'h00;
      rda_r <= 1'b0;
      drx_r <= 1'b0;
      dtx_r <= 1'b0;
    end else begin
      lcr_r <= lcr_nxt;
      mcr_r <= mcr_nxt;
      brk_r <= brk_nxt;
      dmam_r <= dmam_nxt;
      fen_r <= fen_nxt;
      rtrig_r <= rtrig_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      prdata_r <= prdata_nxt;
      txrst_r <= txrst_nxt;
      rxrst_r <= rxrst_nxt;
      sout_r <= sout_nxt;
      loop_rx_r <= loop_rx_nxt;
      sir_r <= sir_nxt;
      sir_cnt_r <= sir_cnt_nxt;
      rda_r <= rda_nxt;
      drx_r <= drx_nxt;
      dtx_r <= dtx_nxt;
    end
  end

  // ==================================================================
  // checks
  brk_alias_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    wr_en && i_paddr == usc_pkg::ADDR_LINE_CTRL |=>
      brk_r == $past(i_pwdata[usc_pkg::LCR_BRK_BIT]))
    else $error("line control write missed break shadow");

  brk_low_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    brk_r && !loop_on && !$past(loop_on) |=> !o_sout)
    else $error("serial output not low during break");

  brk_hold_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    brk_r && !loop_on ##1 brk_r && !loop_on |-> !o_sout)
    else $error("serial output released while break set");

  sir_pulse_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    ir_brk && $rose(o_sir_out_n) |->
      ##[1:300] (!o_sir_out_n || !ir_brk))
    else $error("infrared output not pulsing in break");

  loop_brk_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    loop_on && brk_r |=> o_sout && !o_loop_rx)
    else $error("break not looped back internally");

  dma_mode0_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    !dmam_r && i_tx_level == 5'h00 |=> !o_dma_tx_req_n)
    else $error("mode 0 transmit request missing");

  fen_alias_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    wr_en && i_paddr == usc_pkg::ADDR_FEN_SHADOW |=>
      o_fifo_en == $past(i_pwdata[0]))
    else $error("fifo enable shadow not applied");

  fifo_rst_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    $fell(fen_r) |-> o_tx_ctl_rst && o_rx_ctl_rst)
    else $error("fifo disable did not reset control");

  rx_trig_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    fen_r && rtrig_r == 2'b01 && i_rx_level == 5'h04 |=> o_rx_avail)
    else $error("quarter trigger did not raise data ready");

  dma_mode1_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    dmam_r && fen_r && rtrig_r == 2'b10 && i_rx_level == 5'h07
      && !drx_r && !txrst_r && !rxrst_r |=> o_dma_rx_req_n)
    else $error("mode 1 receive request below trigger");

  loop_def_a: assert property (
    @(posedge i_clk) disable iff (i_srst)
    !mcr_r[usc_pkg::MCR_LOOP_BIT] |=> o_loop_rx)
    else $error("loopback active without modem bit four");
endmodule // usc_shadow

/* tb/usc_far_model.sv */
`timescale 1ns/1ps
// ====================================================================
// far end of the serial line: measures spacing runs
module usc_far_model (
  input wire logic i_clk,
  input wire logic i_sout,
  output logic [15:0] o_low_run
);
  // a break is only seen as a long spacing run, so count it
  always_ff @(posedge i_clk) begin
    o_low_run <= i_sout ? 16'h0000 : o_low_run + 16'h0001;
  end
endmodule // usc_far_model

/* tb/usc_shadow_tb_top.sv */
`timescale 1ns/1ps
module usc_shadow_tb_top;
  logic i_clk, i_srst, psel, pen, pwr, pready, perr;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [4:0] rxl, txl;
  logic sout, sir_n, loop_rx, fen, txr, rxr, avail, txq_n, rxq_n, irq, e;
  logic [15:0] low_run;
  int n_mismatch, n_compared;
  usc_shadow i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
    .i_tx_serial(1'b1), .i_tx_sir_n(1'b1), .i_rx_level(rxl),
    .i_tx_level(txl), .o_sout(sout), .o_sir_out_n(sir_n),
    .o_loop_rx(loop_rx), .o_fifo_en(fen), .o_tx_ctl_rst(txr),
    .o_rx_ctl_rst(rxr), .o_rx_avail(avail), .o_dma_tx_req_n(txq_n),
    .o_dma_rx_req_n(rxq_n), .o_irq(irq));
  usc_far_model i_far (.i_clk(i_clk), .i_sout(sout), .o_low_run(low_run));
  // ==================================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000);
    chk(q, x);
  endtask
  task automatic lvl(input logic [4:0] v);
    @(posedge i_clk);
    rxl <= v;
    wt(3);
  endtask
  task automatic tlv(input logic [4:0] v);
    @(posedge i_clk);
    txl <= v;
    wt(3);
  endtask
  // ==================================================================
  // scenarios
  task automatic t_reset();
    rd(usc_pkg::ADDR_BRK_SHADOW, 32'h0);
    rd(usc_pkg::ADDR_DMAM_SHADOW, 32'h0);
    rd(usc_pkg::ADDR_FEN_SHADOW, 32'h0);
    rd(usc_pkg::ADDR_RTRIG_SHADOW, 32'h0);
    chk(32'(sout), 32'h1);
    chk(32'(rxq_n), 32'h1);
    $display("test reset done");
  endtask
  task automatic t_break();
    wr(usc_pkg::ADDR_IRQ_MASK, 32'h4);
    wr(usc_pkg::ADDR_BRK_SHADOW, 32'h1);
    rd(usc_pkg::ADDR_LINE_CTRL, 32'h40);
    wt(3);
    chk(32'(sout), 32'h0);
    wt(20);
    chk(32'(low_run >= 16'h0014), 32'h1);
    chk(32'(irq), 32'h1);
    wr(usc_pkg::ADDR_LINE_CTRL, 32'h0);
    rd(usc_pkg::ADDR_BRK_SHADOW, 32'h0);
    wt(3);
    chk(32'(sout), 32'h1);
    // status is sticky: still pending after break ends
    chk(32'(irq), 32'h1);
    wr(usc_pkg::ADDR_IRQ_STATUS, 32'h4);
    wt(2);
    chk(32'(irq), 32'h0);
    apb(1'b0, 32'h50001000, 32'h0);
    chk(32'(e), 32'h1);
    $display("test break done");
  endtask
  task automatic t_loop();
    wr(usc_pkg::ADDR_MODEM_CTRL, 32'h10);
    wr(usc_pkg::ADDR_BRK_SHADOW, 32'h1);
    wt(3);
    chk(32'(sout), 32'h1);
    chk(32'(loop_rx), 32'h0);
    wr(usc_pkg::ADDR_BRK_SHADOW, 32'h0);
    wr(usc_pkg::ADDR_MODEM_CTRL, 32'h0);
    $display("test loopback done");
  endtask
  task automatic t_ir();
    int tg;
    logic p;
    tg = 0;
    wr(usc_pkg::ADDR_MODEM_CTRL, 32'h40);
    wt(3);
    chk(32'(sir_n), 32'h1);
    wr(usc_pkg::ADDR_BRK_SHADOW, 32'h1);
    p = sir_n;
    repeat (560) begin
      wt(1);
      if (sir_n !== p) tg++;
      p = sir_n;
    end
    chk(32'(tg >= 2), 32'h1);
    wr(usc_pkg::ADDR_BRK_SHADOW, 32'h0);
    wr(usc_pkg::ADDR_MODEM_CTRL, 32'h0);
    $display("test infrared done");
  endtask
  task automatic t_fifo();
    logic [4:0] th [4];
    int c;
    th = '{5'h01, 5'h04, 5'h08, 5'h0e};
    c = 0;
    wr(usc_pkg::ADDR_FEN_SHADOW, 32'h1);
    wr(usc_pkg::ADDR_DMAM_SHADOW, 32'h1);
    rd(usc_pkg::ADDR_FIFO_CTRL, 32'h09);
    chk(32'(fen), 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(usc_pkg::ADDR_RTRIG_SHADOW, 32'(k));
      rd(usc_pkg::ADDR_FIFO_CTRL, 32'h09 | 32'(k << 6));
      lvl(th[k] - 5'h01);
      chk(32'(avail), 32'h0);
      chk(32'(rxq_n), 32'h1);
      lvl(th[k]);
      chk(32'(avail), 32'h1);
      chk(32'(rxq_n), 32'h0);
      lvl(5'h00);
      chk(32'(rxq_n), 32'h1);
    end
    tlv(5'h0f);
    chk(32'(txq_n), 32'h0);
    tlv(5'h10);
    chk(32'(txq_n), 32'h1);
    wr(usc_pkg::ADDR_DMAM_SHADOW, 32'h0);
    tlv(5'h0f);
    chk(32'(txq_n), 32'h1);
    tlv(5'h00);
    chk(32'(txq_n), 32'h0);
    lvl(5'h01);
    chk(32'(rxq_n), 32'h0);
    lvl(5'h00);
    wr(usc_pkg::ADDR_FEN_SHADOW, 32'h0);
    repeat (4) begin
      #1;
      if (txr === 1'b1 && rxr === 1'b1) c++;
      @(posedge i_clk);
    end
    chk(32'(c), 32'h1);
    chk(32'(fen), 32'h0);
    $display("test fifo done");
  endtask
  // ==================================================================
  // clock, reset, sequence, verdict
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    // full run is under a thousand cycles; this leaves wide margin
    #80000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    i_srst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    rxl = 5'h00;
    txl = 5'h00;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset();
    t_break();
    t_loop();
    t_ir();
    t_fifo();
    stop_test();
  end
endmodule // usc_shadow_tb_top
